// [hdl/dibc_device.sv]
`timescale 1ns/10ps
`include "dibc_map.svh"
// Operation
// R1 - controller uses table only with clock enable high
// R2 - bank m own state must allow command
// R3 - deselect and nop continue ongoing operations
// R4 - decode active read write precharge from pins
// R5 - idle bank n restricts nothing
// R6 - other-bank commands accepted during activate/precharge
// R7 - read to other bank replaces current burst
// R8 - write after read only once data done
// R9 - read interrupting write needs data masking
// R10 - non-concurrent: access period allows only act/pre
// R11 - read-ap precharge starts at earliest legal precharge
// R12 - write-ap precharge starts after write recovery
// R13 - concurrent: any command not interrupting transfer
// R14 - never contend read and write data
// R15 - write-ap to other-bank access delays
// R16 - read-ap to other-bank command delays
// R17 - refresh and mode set only all idle
// R18 - burst terminate only to current burst
// R19 - avoid unspecified sequences, else reinitialize
// R20 - idle only after precharge period elapsed
// R21 - row-active after activate-to-access delay
// R22 - read state lasts until burst ends
// R23 - terminate ends most recent read burst
// R24 - controller tracks per-bank state and counters
module dibc_device
  import dibc_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  input  wire logic       clk_en_in,
  dibc_if.dev             link,
  output logic [11:0]     bank_state_out,
  output logic            cmd_valid_out,
  output logic [3:0]      cmd_out,
  output logic [1:0]      cmd_bank_out,
  output logic            read_burst_out,
  output logic [1:0]      read_bank_out,
  output logic            write_burst_out,
  output logic            illegal_out
);
  localparam logic [3:0] ACT_CYC = 4'(`DIBC_ACT_TO_ACCESS_CYC);
  localparam logic [3:0] PRE_CYC = 4'(`DIBC_PRECHARGE_CYC);
  localparam logic [3:0] HALF_CYC = 4'(`DIBC_HALF_BURST);
  localparam logic [3:0] WR_CYC = 4'(`DIBC_WRITE_RECOVERY_CYC);
  // read data runs latency plus burst; a terminate must still find it live
  localparam logic [3:0] RD_CYC = 4'(`DIBC_READ_LATENCY + `DIBC_HALF_BURST);

  // pins come from the controller's logic on this clock: no synchroniser
  dibc_cmd_t   cmd;
  dibc_state_t st_reg [0:3];
  logic [3:0]  cnt_reg [0:3];
  logic [3:0]  burst_cnt_reg;
  logic [1:0]  read_bank_reg;
  logic        read_on_reg;
  logic        write_on_reg;
  logic [1:0]  write_bank_reg;
  logic        cke_prev_reg;
  logic        all_idle;
  logic        live;

  always_comb begin
    if (link.cs_b) begin
      cmd = DIBC_CMD_DESELECT; // R3
    end else begin
      case ({link.ras_b, link.cas_b, link.we_b}) // R4
        3'b111:  cmd = DIBC_CMD_NOP; // R3
        3'b011:  cmd = DIBC_CMD_ACTIVE;
        3'b101:  cmd = DIBC_CMD_READ;
        3'b100:  cmd = DIBC_CMD_WRITE;
        3'b010:  cmd = DIBC_CMD_PRECHARGE;
        3'b001:  cmd = DIBC_CMD_REFRESH;
        3'b000:  cmd = DIBC_CMD_MODE_SET;
        default: cmd = DIBC_CMD_TERMINATE;
      endcase
    end
  end

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (st_reg[i] != DIBC_ST_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // commands are only decoded with clock enable high on both edges
  assign live = clk_en_in && link.clk_en && cke_prev_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cke_prev_reg <= 1'b0;
    end else if (clk_en_in) begin
      cke_prev_reg <= link.clk_en;
    end
  end

  // per-bank state; other banks never gate a bank's own command (R5 R6)
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 4; i++) begin
        st_reg[i]  <= DIBC_ST_IDLE;
        cnt_reg[i] <= 4'h0;
      end
    end else if (clk_en_in) begin
      for (int i = 0; i < 4; i++) begin
        if (cnt_reg[i] != 4'h0) begin
          cnt_reg[i] <= cnt_reg[i] - 4'h1;
        end
        case (st_reg[i])
          DIBC_ST_ACTIVATING: if (cnt_reg[i] <= 4'h1) st_reg[i] <= DIBC_ST_ACTIVE; // R21
          DIBC_ST_PRECHARGE:  if (cnt_reg[i] <= 4'h1) st_reg[i] <= DIBC_ST_IDLE; // R20
          DIBC_ST_READ_AP, DIBC_ST_WRITE_AP: begin
            if (cnt_reg[i] <= 4'h1) begin
              st_reg[i]  <= DIBC_ST_PRECHARGE; // R11 R12
              cnt_reg[i] <= PRE_CYC;
            end
          end
          DIBC_ST_READ: begin
            if (!read_on_reg || read_bank_reg != 2'(i)) st_reg[i] <= DIBC_ST_ACTIVE; // R22
          end
          DIBC_ST_WRITE: begin
            if (!write_on_reg || write_bank_reg != 2'(i)) st_reg[i] <= DIBC_ST_ACTIVE;
          end
          default: ;
        endcase
      end
      if (live) begin
        case (cmd) // R5 R6
          DIBC_CMD_ACTIVE: begin
            st_reg[link.bank]  <= DIBC_ST_ACTIVATING;
            cnt_reg[link.bank] <= ACT_CYC;
          end
          DIBC_CMD_READ: begin
            st_reg[link.bank]  <= link.auto_precharge_flag ? DIBC_ST_READ_AP : DIBC_ST_READ;
            cnt_reg[link.bank] <= HALF_CYC; // R11
          end
          DIBC_CMD_WRITE: begin
            st_reg[link.bank]  <= link.auto_precharge_flag ? DIBC_ST_WRITE_AP : DIBC_ST_WRITE;
            cnt_reg[link.bank] <= 4'(1 + HALF_CYC + WR_CYC); // R12
          end
          DIBC_CMD_PRECHARGE: begin
            st_reg[link.bank]  <= DIBC_ST_PRECHARGE;
            cnt_reg[link.bank] <= PRE_CYC;
          end
          default: ;
        endcase
      end
    end
  end

  // single shared data burst tracker: newest read replaces older (R7)
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      burst_cnt_reg  <= 4'h0;
      read_on_reg    <= 1'b0;
      write_on_reg   <= 1'b0;
      read_bank_reg  <= 2'h0;
      write_bank_reg <= 2'h0;
    end else if (clk_en_in) begin
      if (burst_cnt_reg > 4'h1) begin
        burst_cnt_reg <= burst_cnt_reg - 4'h1;
      end else begin
        burst_cnt_reg <= 4'h0;
        read_on_reg   <= 1'b0;
        write_on_reg  <= 1'b0;
      end
      if (live && cmd == DIBC_CMD_READ) begin
        read_on_reg   <= 1'b1; // R7
        write_on_reg  <= 1'b0;
        read_bank_reg <= link.bank;
        burst_cnt_reg <= RD_CYC; // R22
      end else if (live && cmd == DIBC_CMD_WRITE) begin
        write_on_reg   <= 1'b1;
        read_on_reg    <= 1'b0;
        write_bank_reg <= link.bank;
        burst_cnt_reg  <= HALF_CYC;
      end else if (live && cmd == DIBC_CMD_TERMINATE) begin
        read_on_reg   <= 1'b0; // R18 R23
        if (!write_on_reg) begin
          burst_cnt_reg <= 4'h0;
        end
      end
    end
  end

  // observation outputs, all registered
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      bank_state_out  <= 12'h000;
      cmd_valid_out   <= 1'b0;
      cmd_out         <= 4'h0;
      cmd_bank_out    <= 2'h0;
      read_burst_out  <= 1'b0;
      read_bank_out   <= 2'h0;
      write_burst_out <= 1'b0;
      illegal_out     <= 1'b0;
    end else if (clk_en_in) begin
      bank_state_out  <= {st_reg[3], st_reg[2], st_reg[1], st_reg[0]};
      cmd_valid_out   <= live && cmd != DIBC_CMD_DESELECT && cmd != DIBC_CMD_NOP;
      cmd_out         <= cmd;
      cmd_bank_out    <= link.bank;
      read_burst_out  <= read_on_reg;
      read_bank_out   <= read_bank_reg;
      write_burst_out <= write_on_reg;
      // sticky: any misuse needs a full restart anyway
      if (live && (cmd == DIBC_CMD_REFRESH || cmd == DIBC_CMD_MODE_SET) && !all_idle) begin
        illegal_out <= 1'b1; // R17 R19
      end
    end
  end
endmodule

// [hdl/dibc_map.svh]
`ifndef DIBC_MAP_SVH
`define DIBC_MAP_SVH
`define DIBC_NUM_BANKS 4
`define DIBC_BURST_LENGTH 4
`define DIBC_HALF_BURST 2
`define DIBC_READ_LATENCY 3
`define DIBC_CLK_PERIOD_PS 5000
`define DIBC_ACT_TO_ACCESS_PS 15000
`define DIBC_PRECHARGE_PERIOD_PS 15000
`define DIBC_WRITE_RECOVERY_PS 15000
`define DIBC_WRITE_TO_READ_CYC 1
`define DIBC_CYC_UP(ps) (((ps) + `DIBC_CLK_PERIOD_PS - 1) / `DIBC_CLK_PERIOD_PS)
`define DIBC_ACT_TO_ACCESS_CYC `DIBC_CYC_UP(`DIBC_ACT_TO_ACCESS_PS)
`define DIBC_PRECHARGE_CYC `DIBC_CYC_UP(`DIBC_PRECHARGE_PERIOD_PS)
`define DIBC_WRITE_RECOVERY_CYC `DIBC_CYC_UP(`DIBC_WRITE_RECOVERY_PS)
`define DIBC_WAP_TO_RW_CYC (1 + `DIBC_HALF_BURST + `DIBC_WRITE_RECOVERY_CYC)
`define DIBC_WAP_TO_RD_CONC_CYC (1 + `DIBC_HALF_BURST + `DIBC_WRITE_TO_READ_CYC)
`define DIBC_WAP_TO_WR_CONC_CYC `DIBC_HALF_BURST
`define DIBC_RAP_TO_RD_CYC `DIBC_HALF_BURST
`define DIBC_RAP_TO_WR_CYC (`DIBC_READ_LATENCY + `DIBC_HALF_BURST)
`define DIBC_AP_TO_PA_CYC 1
`define DIBC_RD_AP_EXTRA_CYC 0
`endif

// [hdl/dibc_pkg.sv]
package dibc_pkg;
  typedef enum logic [3:0] {
    DIBC_CMD_DESELECT  = 4'h0,
    DIBC_CMD_NOP       = 4'h1,
    DIBC_CMD_ACTIVE    = 4'h2,
    DIBC_CMD_READ      = 4'h3,
    DIBC_CMD_WRITE     = 4'h4,
    DIBC_CMD_PRECHARGE = 4'h5,
    DIBC_CMD_REFRESH   = 4'h6,
    DIBC_CMD_MODE_SET  = 4'h7,
    DIBC_CMD_TERMINATE = 4'h8
  } dibc_cmd_t;
  typedef enum logic [2:0] {
    DIBC_ST_IDLE       = 3'b000,
    DIBC_ST_ACTIVATING = 3'b001,
    DIBC_ST_ACTIVE     = 3'b010,
    DIBC_ST_READ       = 3'b011,
    DIBC_ST_WRITE      = 3'b100,
    DIBC_ST_READ_AP    = 3'b101,
    DIBC_ST_WRITE_AP   = 3'b110,
    DIBC_ST_PRECHARGE  = 3'b111
  } dibc_state_t;
endpackage

// [hdl/dibc_if.sv]
`timescale 1ns/10ps
interface dibc_if;
  logic       cs_b;
  logic       ras_b;
  logic       cas_b;
  logic       we_b;
  logic       clk_en;
  logic [1:0] bank;
  logic       auto_precharge_flag;
  modport ctrl (output cs_b, output ras_b, output cas_b, output we_b, output clk_en,
                output bank, output auto_precharge_flag);
  modport dev (input cs_b, input ras_b, input cas_b, input we_b, input clk_en,
               input bank, input auto_precharge_flag);
endinterface

// [hdl/dibc_ctrl.sv]
`timescale 1ns/10ps
`include "dibc_map.svh"
module dibc_ctrl
  import dibc_pkg::*;
#(
  parameter bit CONCURRENT_AP = 1'b0
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  input  wire logic       clk_en_in,
  input  wire logic       req_valid_in,
  input  wire dibc_cmd_t  req_cmd_in,
  input  wire logic [1:0] req_bank_in,
  input  wire logic       req_ap_in,
  output logic            req_ready_out,
  output logic            req_done_out,
  output logic            mask_out,
  dibc_if.ctrl            link
);
  localparam logic [4:0] ACT_CYC = 5'(`DIBC_ACT_TO_ACCESS_CYC);
  localparam logic [4:0] PRE_CYC = 5'(`DIBC_PRECHARGE_CYC);
  localparam logic [4:0] HALF_CYC = 5'(`DIBC_HALF_BURST);
  localparam logic [4:0] WAP_RW = 5'(`DIBC_WAP_TO_RW_CYC);
  localparam logic [4:0] WAP_RD_C = 5'(`DIBC_WAP_TO_RD_CONC_CYC);
  localparam logic [4:0] WAP_WR_C = 5'(`DIBC_WAP_TO_WR_CONC_CYC);
  localparam logic [4:0] RAP_RD = 5'(`DIBC_RAP_TO_RD_CYC);
  localparam logic [4:0] RAP_WR = 5'(`DIBC_RAP_TO_WR_CYC);
  localparam logic [4:0] AP_PA = 5'(`DIBC_AP_TO_PA_CYC);

  dibc_state_t st_reg [0:3];
  logic [4:0]  busy_reg [0:3];
  logic [4:0]  rd_gap_reg;
  logic [4:0]  wr_gap_reg;
  logic [4:0]  pa_gap_reg;
  logic [4:0]  data_reg;
  logic        all_idle;
  logic        ok;
  logic        take;

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (st_reg[i] != DIBC_ST_IDLE || busy_reg[i] != 5'h0) all_idle = 1'b0;
    end
    case (req_cmd_in)
      DIBC_CMD_ACTIVE:    ok = st_reg[req_bank_in] == DIBC_ST_IDLE && pa_gap_reg == 5'h0; // R2
      DIBC_CMD_PRECHARGE: ok = busy_reg[req_bank_in] == 5'h0 && pa_gap_reg == 5'h0;
      DIBC_CMD_READ:      ok = st_reg[req_bank_in] == DIBC_ST_ACTIVE && rd_gap_reg == 5'h0; // R10 R16
      DIBC_CMD_WRITE:     ok = st_reg[req_bank_in] == DIBC_ST_ACTIVE && wr_gap_reg == 5'h0
                               && data_reg == 5'h0; // R8 R14
      DIBC_CMD_REFRESH,
      DIBC_CMD_MODE_SET:  ok = all_idle; // R17
      DIBC_CMD_TERMINATE: ok = data_reg != 5'h0; // R18
      default:            ok = 1'b1;
    endcase
  end

  assign take = req_valid_in && req_ready_out && ok; // R19

  // per-bank tracking in whole clock periods
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 4; i++) begin
        st_reg[i]   <= DIBC_ST_IDLE;
        busy_reg[i] <= 5'h0;
      end
    end else if (clk_en_in) begin
      for (int i = 0; i < 4; i++) begin
        if (busy_reg[i] > 5'h1) begin
          busy_reg[i] <= busy_reg[i] - 5'h1; // R24
        end else begin
          busy_reg[i] <= 5'h0;
          if (st_reg[i] == DIBC_ST_ACTIVATING) st_reg[i] <= DIBC_ST_ACTIVE;
          if (st_reg[i] == DIBC_ST_PRECHARGE) st_reg[i] <= DIBC_ST_IDLE;
        end
      end
      if (take) begin
        case (req_cmd_in)
          DIBC_CMD_ACTIVE: begin
            st_reg[req_bank_in]   <= DIBC_ST_ACTIVATING;
            busy_reg[req_bank_in] <= ACT_CYC;
          end
          DIBC_CMD_READ, DIBC_CMD_WRITE: begin
            if (req_ap_in) begin
              st_reg[req_bank_in]   <= DIBC_ST_PRECHARGE; // R11 R12
              busy_reg[req_bank_in] <= 5'(WAP_RW + PRE_CYC);
            end
          end
          DIBC_CMD_PRECHARGE: begin
            st_reg[req_bank_in]   <= DIBC_ST_PRECHARGE;
            busy_reg[req_bank_in] <= PRE_CYC;
          end
          default: ;
        endcase
      end
    end
  end

  // cross-bank gaps after auto precharge accesses; data bus gap after every read or write
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rd_gap_reg <= 5'h0;
      wr_gap_reg <= 5'h0;
      pa_gap_reg <= 5'h0;
      data_reg   <= 5'h0;
    end else if (clk_en_in) begin
      rd_gap_reg <= (rd_gap_reg != 5'h0) ? rd_gap_reg - 5'h1 : 5'h0;
      wr_gap_reg <= (wr_gap_reg != 5'h0) ? wr_gap_reg - 5'h1 : 5'h0;
      pa_gap_reg <= (pa_gap_reg != 5'h0) ? pa_gap_reg - 5'h1 : 5'h0;
      data_reg   <= (data_reg != 5'h0) ? data_reg - 5'h1 : 5'h0;
      if (take && req_cmd_in == DIBC_CMD_WRITE) begin
        data_reg <= HALF_CYC;
        if (req_ap_in) begin
          rd_gap_reg <= 5'(CONCURRENT_AP ? WAP_RD_C - 5'h1 : WAP_RW - 5'h1); // R15 R13
          wr_gap_reg <= 5'(CONCURRENT_AP ? WAP_WR_C - 5'h1 : WAP_RW - 5'h1);
          pa_gap_reg <= 5'(AP_PA - 5'h1);
        end
      end else if (take && req_cmd_in == DIBC_CMD_READ) begin
        data_reg <= 5'(RAP_WR - 5'h1); // R14
        if (req_ap_in) begin
          rd_gap_reg <= 5'(RAP_RD - 5'h1); // R16
          wr_gap_reg <= 5'(RAP_WR - 5'h1);
          pa_gap_reg <= 5'(AP_PA - 5'h1);
        end
      end else if (take && req_cmd_in == DIBC_CMD_TERMINATE) begin
        data_reg <= 5'h0;
      end
    end
  end

  // pin drive; idle cycles present as deselect with clock enable high (R1 R3)
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      link.cs_b                <= 1'b1;
      link.ras_b               <= 1'b1;
      link.cas_b               <= 1'b1;
      link.we_b                <= 1'b1;
      link.clk_en              <= 1'b0;
      link.bank                <= 2'h0;
      link.auto_precharge_flag <= 1'b0;
      req_ready_out            <= 1'b0;
      req_done_out             <= 1'b0;
      mask_out                 <= 1'b0;
    end else if (clk_en_in) begin
      link.clk_en   <= 1'b1; // R1
      req_ready_out <= link.clk_en;
      req_done_out  <= take;
      // read while data_reg still runs from an earlier write or read raises mask_out
      mask_out      <= take && req_cmd_in == DIBC_CMD_READ && data_reg != 5'h0; // R9
      link.cs_b     <= !take;
      link.bank     <= req_bank_in;
      link.auto_precharge_flag <= req_ap_in;
      case (take ? req_cmd_in : DIBC_CMD_NOP)
        DIBC_CMD_ACTIVE:    {link.ras_b, link.cas_b, link.we_b} <= 3'b011;
        DIBC_CMD_READ:      {link.ras_b, link.cas_b, link.we_b} <= 3'b101;
        DIBC_CMD_WRITE:     {link.ras_b, link.cas_b, link.we_b} <= 3'b100;
        DIBC_CMD_PRECHARGE: {link.ras_b, link.cas_b, link.we_b} <= 3'b010;
        DIBC_CMD_REFRESH:   {link.ras_b, link.cas_b, link.we_b} <= 3'b001;
        DIBC_CMD_MODE_SET:  {link.ras_b, link.cas_b, link.we_b} <= 3'b000;
        DIBC_CMD_TERMINATE: {link.ras_b, link.cas_b, link.we_b} <= 3'b110;
        default:            {link.ras_b, link.cas_b, link.we_b} <= 3'b111; // R3
      endcase
    end
  end
endmodule

// [sim/dibc_checker.sv]
`timescale 1ns/10ps
module dibc_checker (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  input  wire logic       cs_b,
  input  wire logic       ras_b,
  input  wire logic       cas_b,
  input  wire logic       we_b,
  input  wire logic       clk_en,
  input  wire logic [1:0] bank,
  input  wire logic       auto_precharge_flag
);
  logic       act_c;
  logic       pre_c;
  logic       rd_c;
  logic       wr_c;
  logic       term_c;
  logic [2:0] rd_age_reg;
  logic [1:0] rd_bank_reg;

  assign act_c  = !cs_b && !ras_b && cas_b && we_b;
  assign rd_c   = !cs_b && ras_b && !cas_b && we_b;
  assign wr_c   = !cs_b && ras_b && !cas_b && !we_b;
  assign pre_c  = !cs_b && !ras_b && cas_b && !we_b;
  assign term_c = !cs_b && ras_b && cas_b && !we_b;

  // cycles since last read; saturates so an old read never blocks a write
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || term_c) begin
      rd_age_reg <= 3'h7;
    end else if (rd_c) begin
      rd_age_reg <= 3'h1;
    end else if (rd_age_reg != 3'h7) begin
      rd_age_reg <= rd_age_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rd_bank_reg <= 2'h0;
    end else if (rd_c) begin
      rd_bank_reg <= bank;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_wr_ap;
    wr_c && auto_precharge_flag;
  endsequence
  sequence s_rd_ap;
    rd_c && auto_precharge_flag;
  endsequence

  a_reset_deselect: assert property ($rose(rst_b_in) |-> cs_b && !clk_en)
    else $error("command pins not deselected after reset");
  a_cke_held_high: assert property (!cs_b |-> clk_en && $past(clk_en))
    else $error("command issued without clock enable on two edges");
  a_wap_access_gap: assert property (s_wr_ap |=> (!(rd_c || wr_c))[*5])
    else $error("access too soon after write with auto precharge");
  a_rap_read_gap: assert property (s_rd_ap |=> !rd_c)
    else $error("read too soon after read with auto precharge");
  a_read_write_gap: assert property (wr_c |-> rd_age_reg >= 3'h5)
    else $error("write overlaps read data");
  a_term_read_bank: assert property (term_c |-> bank == rd_bank_reg)
    else $error("terminate aimed at another bank");
  a_act_access_delay: assert property (act_c |=> !((rd_c || wr_c) && bank == $past(bank))
    ##1 !((rd_c || wr_c) && bank == $past(bank, 2)))
    else $error("access before activate delay elapsed");
  a_pre_idle_delay: assert property (pre_c |=> !(act_c && bank == $past(bank))
    ##1 !(act_c && bank == $past(bank, 2)))
    else $error("activate before precharge period elapsed");
endmodule

// [sim/ddr_interbank_command_rules_test.sv]
`timescale 1ns/10ps
module ddr_interbank_command_rules_test;
  import dibc_pkg::*;
  logic        clk_sys_in   = 1'b0;
  logic        rst_b_in     = 1'b0;
  logic        clk_en_in    = 1'b1;
  logic        req_valid_in = 1'b0;
  dibc_cmd_t   req_cmd_in   = DIBC_CMD_ACTIVE;
  logic [1:0]  req_bank_in  = 2'h0;
  logic        req_ap_in    = 1'b0;
  logic        mask_hit     = 1'b0;
  logic        req_ready_out;
  logic        req_done_out;
  logic        mask_out;
  logic [11:0] bank_state_out;
  logic        cmd_valid_out;
  logic [3:0]  cmd_out;
  logic [1:0]  cmd_bank_out;
  logic        read_burst_out;
  logic [1:0]  read_bank_out;
  logic        write_burst_out;
  logic        illegal_out;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  int          t_last    = 0;
  int          t_gap     = 0;

  dibc_if link ();
  dibc_ctrl u_dibc_ctrl (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
    .req_ap_in(req_ap_in), .req_ready_out(req_ready_out), .req_done_out(req_done_out),
    .mask_out(mask_out), .link(link.ctrl));
  dibc_device u_dibc_device (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .link(link.dev), .bank_state_out(bank_state_out), .cmd_valid_out(cmd_valid_out),
    .cmd_out(cmd_out), .cmd_bank_out(cmd_bank_out), .read_burst_out(read_burst_out),
    .read_bank_out(read_bank_out), .write_burst_out(write_burst_out), .illegal_out(illegal_out));
  dibc_checker u_dibc_checker (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cs_b(link.cs_b),
    .ras_b(link.ras_b), .cas_b(link.cas_b), .we_b(link.we_b), .clk_en(link.clk_en),
    .bank(link.bank), .auto_precharge_flag(link.auto_precharge_flag));

  always #2.5 clk_sys_in = ~clk_sys_in;

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // run needs about 70 cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after an edge; valid held until done is seen
  task automatic issue(input dibc_cmd_t c, input logic [1:0] b, input logic a);
    int n;
    n = 0;
    req_cmd_in   = c;
    req_bank_in  = b;
    req_ap_in    = a;
    req_valid_in = 1'b1;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end while (req_done_out !== 1'b1 && n < 50);
    req_valid_in = 1'b0;
    mask_hit     = mask_out;
    t_gap  = cyc - t_last;
    t_last = cyc;
    check(12'(n < 50), 12'h001);
    @(posedge clk_sys_in);
    #1;
    check({3'h0, cmd_valid_out, cmd_out, 2'h0, cmd_bank_out}, {3'h0, 1'b1, c, 2'h0, b});
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_in);
    #1 rst_b_in = 1'b1;
    check(bank_state_out, 12'h000);
    repeat (2) @(posedge clk_sys_in);
    #1;
    for (int i = 0; i < 4; i++) begin
      issue(DIBC_CMD_ACTIVE, 2'(i), 1'b0);
    end
    // freeze mid-activation: states must not advance
    clk_en_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1;
    check(bank_state_out, {DIBC_ST_IDLE, DIBC_ST_ACTIVATING, DIBC_ST_ACTIVE, DIBC_ST_ACTIVE});
    clk_en_in = 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1;
    check(bank_state_out, {DIBC_ST_ACTIVE, DIBC_ST_ACTIVE, DIBC_ST_ACTIVE, DIBC_ST_ACTIVE});
    issue(DIBC_CMD_WRITE, 2'h0, 1'b1);
    issue(DIBC_CMD_READ, 2'h1, 1'b0);
    check(12'(t_gap >= 6), 12'h001);
    check(mask_hit, 1'b0);
    issue(DIBC_CMD_READ, 2'h2, 1'b0);
    @(posedge clk_sys_in);
    #1;
    check({read_burst_out, read_bank_out}, 12'h006);
    issue(DIBC_CMD_TERMINATE, 2'h2, 1'b0);
    @(posedge clk_sys_in);
    #1;
    check(read_burst_out, 1'b0);
    issue(DIBC_CMD_READ, 2'h1, 1'b1);
    issue(DIBC_CMD_WRITE, 2'h3, 1'b0);
    check(12'(t_gap >= 5), 12'h001);
    issue(DIBC_CMD_READ, 2'h2, 1'b0);
    check(mask_hit, 1'b1);
    issue(DIBC_CMD_PRECHARGE, 2'h2, 1'b0);
    issue(DIBC_CMD_PRECHARGE, 2'h3, 1'b0);
    repeat (12) @(posedge clk_sys_in);
    #1;
    check(bank_state_out, 12'h000);
    issue(DIBC_CMD_REFRESH, 2'h0, 1'b0);
    issue(DIBC_CMD_MODE_SET, 2'h0, 1'b0);
    check(illegal_out, 1'b0);
    finish_test();
  end
endmodule
